/* include/cts_core_pkg.sv */
`default_nettype none
package cts_core_pkg;

  // ----------------------------------------------------------------
  // elaboration option encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CTS_MUL_NONE   = 2'h0,
    CTS_MUL_SLOW   = 2'h1,
    CTS_MUL_FAST   = 2'h2,
    CTS_MUL_SINGLE = 2'h3
  } cts_mul_e;

  typedef enum logic [1:0] {
    CTS_BIT_NONE     = 2'h0,
    CTS_BIT_BALANCED = 2'h1,
    CTS_BIT_NO_ZBE   = 2'h2,
    CTS_BIT_FULL     = 2'h3
  } cts_bit_e;

  typedef enum logic [1:0] {
    CTS_RF_FF    = 2'h0,
    CTS_RF_FPGA  = 2'h1,
    CTS_RF_LATCH = 2'h2
  } cts_rf_e;

  typedef logic [31:0]  cts_seed_t;
  typedef logic [159:0] cts_perm_t;

  // identity permutation: output bit i takes lfsr bit i
  function automatic cts_perm_t cts_identity_perm();
    cts_perm_t p;
    p = '0;
    for (int i = 0; i < 32; i++) begin
      p[i*5 +: 5] = 5'(i);
    end
    return p;
  endfunction

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam logic [31:0] CTS_BOOT_OFFSET    = 32'h0000_0080;
  localparam logic [31:0] CTS_FETCH_STEP     = 32'h0000_0004;
  localparam logic [3:0]  CTS_FETCH_ON_CODE  = 4'h5;
  localparam logic [31:0] CTS_DBG_ENTRY_DEF  = 32'h1A11_0800;
  localparam logic [31:0] CTS_DBG_FAULT_DEF  = 32'h1A11_0808;
  localparam cts_seed_t   CTS_SEED_DEF       = 32'h5A3C_96E1; // arbitrary value
  localparam logic [31:0] CTS_LFSR_TAPS      = 32'h8020_0003;
  localparam int          CTS_REGIONS_DEF    = 4;
  localparam int          CTS_CNT_WIDTH_DEF  = 40;
  localparam int          CTS_CNT_MAX        = 10;
  localparam int          CTS_REGS_FULL      = 32;
  localparam int          CTS_REGS_REDUCED   = 16;

  // register offsets (byte addresses)
  localparam logic [7:0] CTS_REG_HART   = 8'h00;
  localparam logic [7:0] CTS_REG_CTRL   = 8'h04;
  localparam logic [7:0] CTS_REG_STATUS = 8'h08;
  localparam logic [7:0] CTS_REG_CONFIG = 8'h0C;
  localparam logic [7:0] CTS_REG_PC     = 8'h10;
  localparam logic [7:0] CTS_REG_LFSR   = 8'h14;
  localparam logic [7:0] CTS_REG_CNT0   = 8'h18;

  // control register field
  localparam int CTS_CTRL_HOLD_BIT = 0;
  localparam logic CTS_CTRL_RST    = 1'b0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } cts_fetch_s;

  typedef struct packed {
    logic minor;
    logic majorInternal;
    logic majorBus;
  } cts_alert_s;

endpackage
`default_nettype wire

/* rtl/cts_core_shell.sv */
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module cts_core_shell
  import cts_core_pkg::*;
#(
  parameter bit          protection_unit_on        = 1'b0,
  parameter int          protection_match_granule  = 0,
  parameter int          protection_region_count   = CTS_REGIONS_DEF,
  parameter int          event_counter_count       = 0,
  parameter int          event_counter_width       = CTS_CNT_WIDTH_DEF,
  parameter bit          reduced_register_base     = 1'b0,
  parameter cts_mul_e    multiply_variant_select   = CTS_MUL_FAST,
  parameter cts_bit_e    bitmanip_variant_select   = CTS_BIT_NONE,
  parameter cts_rf_e     register_store_style      = CTS_RF_FF,
  parameter bit          branch_target_adder_on    = 1'b0,
  parameter bit          fetch_cache_on            = 1'b0,
  parameter bit          fetch_cache_correction_on = 1'b0,
  parameter bit          fetch_cache_scrambling_on = 1'b0,
  parameter bit          hardened_mode_on          = 1'b0,
  parameter cts_seed_t   dummy_generator_seed      = CTS_SEED_DEF,
  parameter cts_perm_t   dummy_generator_permutation = cts_identity_perm(),
  parameter bit          debug_trigger_on          = 1'b0,
  parameter logic [31:0] debug_entry_vector        = CTS_DBG_ENTRY_DEF,
  parameter logic [31:0] debug_fault_vector        = CTS_DBG_FAULT_DEF
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                testEnable,
  input  wire logic                testResetLowIn,
  input  wire logic [9:0]          ramCfgIn,
  output var  logic [9:0]          ramCfgOut,
  input  wire logic [31:0]         threadIdentifierIn,
  input  wire logic [31:0]         bootAddrIn,
  input  wire logic [3:0]          fetchEnableIn,
  output var  cts_fetch_s          fetchReq,
  input  wire logic                instrGnt,
  input  wire logic                instrRvalid,
  input  wire logic                instrErr,
  input  wire logic                branchTaken,
  input  wire logic [31:0]         branchTarget,
  input  wire logic                debugEnter,
  input  wire logic                debugException,
  input  wire logic                triggerHit,
  input  wire logic                wfiExec,
  input  wire logic                dataOutstanding,
  input  wire logic                irqPending,
  input  wire logic                debugReq,
  input  wire logic                minorFault,
  input  wire logic                majorInternalFault,
  input  wire logic                majorBusFault,
  input  wire logic [CTS_CNT_MAX-1:0] perfEvent,
  output var  cts_alert_s          alerts,
  output var  logic                coreSleep,
  output var  logic                clkGateEnable,
  output var  logic [31:0]         dummyInstr,
  input  wire logic [7:0]          regAddr,
  input  wire logic [31:0]         regWdata,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  output var  logic [31:0]         regRdata
);

  // ----------------------------------------------------------------
  // configuration legality
  // ----------------------------------------------------------------
  localparam bit RegionBad = protection_unit_on &&
    (protection_region_count < 1 || protection_region_count > 16);
  localparam bit GranuleBad = protection_match_granule < 0 ||
    protection_match_granule > 31;
  localparam bit CounterBad = event_counter_count < 0 ||
    event_counter_count > CTS_CNT_MAX ||
    event_counter_width < 1 || event_counter_width > 64;
  localparam bit HardenBad = hardened_mode_on &&
    multiply_variant_select == CTS_MUL_NONE;
  localparam bit ConfigBad = RegionBad | GranuleBad | CounterBad | HardenBad;
  localparam int IntRegs = reduced_register_base ? CTS_REGS_REDUCED
                                                 : CTS_REGS_FULL;
  localparam int RegionsEff = protection_unit_on ? protection_region_count : 0;
  localparam int NumTriggers = debug_trigger_on ? 1 : 0;

  typedef enum logic [1:0] {
    CTS_F_IDLE  = 2'b00,
    CTS_F_REQ   = 2'b01,
    CTS_F_WAIT  = 2'b10,
    CTS_F_STALL = 2'b11
  } cts_fetch_e;

  // ----------------------------------------------------------------
  // reset selection and synchroniser
  // ----------------------------------------------------------------
  logic rstMuxN;
  logic rstMeta_ff;
  logic rstSync_ff;

  // test mode hands reset to the test reset pin
  assign rstMuxN = testEnable ? testResetLowIn : rst_n;

  // two-stage release of the selected reset
  always_ff @(posedge clk or negedge rstMuxN) begin
    if (!rstMuxN) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  logic        hold_ff;
  logic        ctrlWrite;
  logic [31:0] statusWord;
  logic [31:0] configWord;
  logic [31:0] readMux;
  logic [31:0] pc_ff;
  logic [31:0] lfsr_ff;
  logic [63:0] cnt_ff [CTS_CNT_MAX];
  cts_fetch_e  state_ff;
  logic        wfiPend_ff;
  logic        bootDone_ff;

  assign ctrlWrite = regWrite && (regAddr == CTS_REG_CTRL);

  // control register: fetch hold bit
  always_ff @(posedge clk or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      hold_ff <= CTS_CTRL_RST;
    end else if (ctrlWrite) begin
      hold_ff <= regWdata[CTS_CTRL_HOLD_BIT];
    end
  end

  // status and configuration words
  assign statusWord = {25'h0, NumTriggers[0], wfiPend_ff, bootDone_ff,
                       state_ff, coreSleep, hold_ff};
  assign configWord = {ConfigBad, hardened_mode_on, fetch_cache_on,
                       branch_target_adder_on, register_store_style,
                       bitmanip_variant_select, multiply_variant_select,
                       IntRegs == CTS_REGS_REDUCED,
                       6'(event_counter_width), 4'(event_counter_count),
                       5'(RegionsEff), 5'(protection_match_granule),
                       protection_unit_on};

  // read selection; unmapped offsets read zero
  assign readMux = (regAddr == CTS_REG_HART)   ? threadIdentifierIn :
                   (regAddr == CTS_REG_CTRL)   ? {31'h0, hold_ff} :
                   (regAddr == CTS_REG_STATUS) ? statusWord :
                   (regAddr == CTS_REG_CONFIG) ? configWord :
                   (regAddr == CTS_REG_PC)     ? pc_ff :
                   (regAddr == CTS_REG_LFSR)   ? lfsr_ff :
                   (regAddr == CTS_REG_CNT0)   ? cnt_ff[0][31:0] : 32'h0;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      regRdata <= 32'h0;
    end else begin
      regRdata <= regRead ? readMux : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // fetch sequencer
  // ----------------------------------------------------------------
  logic        fetchAllowed;
  logic        redirect;
  logic [31:0] redirectPc;
  logic        needStall;
  logic        dropResp_ff;
  logic [31:0] stallPc_ff;
  cts_fetch_e  nxt_state;
  logic [31:0] nxt_pc;

  // fetch permission needs the exact enabling code
  assign fetchAllowed = (fetchEnableIn == CTS_FETCH_ON_CODE) &&
                        !hold_ff && !wfiPend_ff && bootDone_ff;

  // debug vectors take priority over branches
  assign redirect   = debugEnter || debugException || branchTaken;
  assign redirectPc = debugException ? debug_fault_vector :
                      debugEnter     ? debug_entry_vector : branchTarget;
  // without the target adder a taken branch outside the wait state costs an extra cycle
  assign needStall  = branchTaken && !debugEnter && !debugException &&
                      !branch_target_adder_on;

  // next state and next fetch address
  always_comb begin
    nxt_state = state_ff;
    nxt_pc    = pc_ff;
    case (state_ff)
      CTS_F_IDLE: begin
        if (fetchAllowed) begin
          nxt_state = CTS_F_REQ;
        end
      end
      CTS_F_REQ: begin
        if (instrGnt) begin
          nxt_state = CTS_F_WAIT;
        end
      end
      CTS_F_WAIT: begin
        if (instrRvalid) begin
          nxt_state = fetchAllowed ? CTS_F_REQ : CTS_F_IDLE;
          if (!dropResp_ff) begin
            nxt_pc = pc_ff + CTS_FETCH_STEP;
          end
        end
      end
      CTS_F_STALL: begin
        nxt_state = CTS_F_IDLE;
        nxt_pc    = stallPc_ff;
      end
      default: begin
        nxt_state = CTS_F_IDLE;
      end
    endcase
    if (redirect && state_ff != CTS_F_WAIT) begin
      nxt_state = needStall ? CTS_F_STALL : CTS_F_IDLE;
      nxt_pc    = needStall ? pc_ff : redirectPc;
    end else if (redirect) begin
      nxt_pc = redirectPc;
    end
  end

  // sequencer registers; boot address is caught after reset release
  always_ff @(posedge clk or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      state_ff    <= CTS_F_IDLE;
      pc_ff       <= 32'h0;
      bootDone_ff <= 1'b0;
      stallPc_ff  <= 32'h0;
      fetchReq    <= '0;
    end else if (!bootDone_ff) begin
      pc_ff       <= bootAddrIn + CTS_BOOT_OFFSET;
      bootDone_ff <= 1'b1;
    end else begin
      state_ff      <= nxt_state;
      pc_ff         <= nxt_pc;
      stallPc_ff    <= redirect ? redirectPc : stallPc_ff;
      fetchReq.req  <= (nxt_state == CTS_F_REQ);
      fetchReq.addr <= nxt_pc;
    end
  end

  // a redirect while a response is due throws that response away
  always_ff @(posedge clk or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      dropResp_ff <= 1'b0;
    end else if (state_ff == CTS_F_WAIT && instrRvalid) begin
      dropResp_ff <= 1'b0;
    end else if (redirect && state_ff == CTS_F_WAIT) begin
      dropResp_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sleep and clock gating
  // ----------------------------------------------------------------
  logic wake;
  logic nxt_sleep;

  assign wake      = irqPending || debugReq;
  assign nxt_sleep = wfiPend_ff && !wake && !dataOutstanding &&
                     (state_ff == CTS_F_IDLE);

  // wait-for-interrupt latch; a wake in the same cycle wins
  always_ff @(posedge clk or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      wfiPend_ff    <= 1'b0;
      coreSleep     <= 1'b0;
      clkGateEnable <= 1'b1;
    end else begin
      wfiPend_ff    <= (wfiPend_ff || wfiExec) && !wake;
      coreSleep     <= nxt_sleep;
      clkGateEnable <= testEnable || !nxt_sleep;
    end
  end

  // ----------------------------------------------------------------
  // alerts
  // ----------------------------------------------------------------
  logic minorSeen_ff;

  // minor alert fires once on each new fault; majors follow the fault level, and the bus major also rises on a fetch error response
  always_ff @(posedge clk or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      minorSeen_ff         <= 1'b0;
      alerts               <= '0;
    end else begin
      minorSeen_ff         <= minorFault;
      alerts.minor         <= minorFault && !minorSeen_ff;
      alerts.majorInternal <= majorInternalFault;
      alerts.majorBus      <= majorBusFault ||
                              (state_ff == CTS_F_WAIT && instrRvalid && instrErr);
    end
  end

  // ----------------------------------------------------------------
  // cache memory configuration and dummy instruction source
  // ----------------------------------------------------------------
  function automatic logic [31:0] permute(input logic [31:0] v, input cts_perm_t p);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[p[i*5 +: 5]];
    end
    return r;
  endfunction

  // cache RAM configuration only matters when the cache is present
  always_ff @(posedge clk or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      ramCfgOut <= 10'h000;
    end else begin
      ramCfgOut <= fetch_cache_on ? ramCfgIn : 10'h000;
    end
  end

  // seeded Galois LFSR with permuted output
  always_ff @(posedge clk or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      lfsr_ff    <= dummy_generator_seed;
      dummyInstr <= 32'h0;
    end else if (hardened_mode_on) begin
      lfsr_ff    <= lfsr_ff[0] ? ((lfsr_ff >> 1) ^ CTS_LFSR_TAPS) : (lfsr_ff >> 1);
      dummyInstr <= permute(lfsr_ff, dummy_generator_permutation);
    end
  end

  // ----------------------------------------------------------------
  // event counters
  // ----------------------------------------------------------------
  for (genvar g = 0; g < CTS_CNT_MAX; g++) begin : gCnt
    if (g < event_counter_count) begin : gOn
      // counter wraps at its configured width
      always_ff @(posedge clk or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
          cnt_ff[g] <= 64'h0;
        end else if (perfEvent[g]) begin
          cnt_ff[g] <= (cnt_ff[g] + 64'h1) & ((64'h1 << event_counter_width) - 64'h1);
        end
      end
    end else begin : gOff
      assign cnt_ff[g] = 64'h0;
    end
  end

  // trigger hits are only tied off; they never act as debug entries, even when support is on
  logic unusedTrig;
  assign unusedTrig = triggerHit & debug_trigger_on;

endmodule // cts_core_shell
`default_nettype wire

/* verification/cts_core_shell_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module cts_core_shell_monitor
  import cts_core_pkg::*;
#(
  parameter bit fetch_cache_on = 1'b0
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       testEnable,
  input wire logic [9:0] ramCfgIn,
  input wire logic [9:0] ramCfgOut,
  input wire logic [31:0] threadIdentifierIn,
  input wire logic [3:0] fetchEnableIn,
  input wire cts_fetch_s fetchReq,
  input wire logic       instrGnt,
  input wire logic       branchTaken,
  input wire logic       debugEnter,
  input wire logic       debugException,
  input wire logic       dataOutstanding,
  input wire logic       irqPending,
  input wire logic       debugReq,
  input wire logic       minorFault,
  input wire logic       majorInternalFault,
  input wire logic       majorBusFault,
  input wire cts_alert_s alerts,
  input wire logic       coreSleep,
  input wire logic       clkGateEnable,
  input wire logic [7:0] regAddr,
  input wire logic       regRead,
  input wire logic [31:0] regRdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // fetch handshake and permission
  fetch_hold_a: assert property (fetchReq.req && !instrGnt && !debugEnter
    && !debugException && !branchTaken |=> fetchReq.req && $stable(fetchReq.addr))
    else $error("fetch request dropped before grant");
  fetch_perm_a: assert property ($rose(fetchReq.req)
    |-> $past(fetchEnableIn) == CTS_FETCH_ON_CODE) else $error("fetch while disabled");
  // sleep indication
  sleep_wake_a: assert property (irqPending || debugReq |=> !coreSleep)
    else $error("sleep kept during wake");
  sleep_busy_a: assert property (dataOutstanding |=> !coreSleep)
    else $error("sleep with data outstanding");
  // alert outputs
  minor_pulse_a: assert property ($rose(minorFault) |=> alerts.minor)
    else $error("minor alert missing");
  minor_once_a: assert property (alerts.minor |=> !alerts.minor)
    else $error("minor alert longer than one cycle");
  major_int_a: assert property (majorInternalFault |=> alerts.majorInternal)
    else $error("internal major alert missing");
  major_bus_a: assert property (majorBusFault |=> alerts.majorBus)
    else $error("bus major alert missing");
  // test mode, ram config, register reads
  test_gate_a: assert property (testEnable && $past(testEnable) |-> clkGateEnable)
    else $error("clock gate not forced in test mode");
  ram_cfg_a: assert property ($changed(ramCfgIn) |=> ramCfgOut
    == (fetch_cache_on ? $past(ramCfgIn) : 10'h000)) else $error("ram config not passed");
  hart_read_a: assert property (regRead && regAddr == CTS_REG_HART
    |=> regRdata == $past(threadIdentifierIn)) else $error("hart id read wrong");
  rdata_idle_a: assert property (!regRead |=> regRdata == 32'h0)
    else $error("read data outside read cycle");
endmodule // cts_core_shell_monitor

bind cts_core_shell cts_core_shell_monitor #(.fetch_cache_on(fetch_cache_on)) u_mon (
  .clk, .rst_n, .testEnable, .ramCfgIn, .ramCfgOut, .threadIdentifierIn, .fetchEnableIn,
  .fetchReq, .instrGnt, .branchTaken, .debugEnter, .debugException,
  .dataOutstanding, .irqPending, .debugReq, .minorFault,
  .majorInternalFault, .majorBusFault, .alerts, .coreSleep, .clkGateEnable, .regAddr,
  .regRead, .regRdata
);
`default_nettype wire

/* verification/cts_core_shell_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cts_core_shell_tb
  import cts_core_pkg::*;
;
  localparam logic [31:0] BOOT = 32'h0000_4000;
  localparam logic [31:0] HART = 32'h0000_0007;
  localparam logic [31:0] BRANCH = 32'h0000_8000;
  localparam logic [31:0] CFG = {4'h3, 2'h2, 2'h3, 2'h3, 1'b1, 6'h28, 4'hA, 5'h10, 5'h03, 1'b1};
  logic clk = 1'b0, rst_n = 1'b0, testEnable = 1'b0, slow = 1'b0, wfiExec = 1'b0;
  logic dataOutstanding = 1'b0, regWrite = 1'b0, regRead = 1'b0, instrGnt, instrRvalid;
  logic instrErr, coreSleep, clkGateEnable, branchTaken = 1'b0;
  logic [1:0] wk = 2'h0, dbg = 2'h0;
  logic [2:0] flt = 3'h0;
  logic [3:0] fetchEnableIn = CTS_FETCH_ON_CODE;
  logic [9:0] ramCfgIn = 10'h000, perfEvent = 10'h000, ramCfgOut;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, hartId = HART, bootAddr = BOOT;
  logic [31:0] branchTarget = 32'h0, dummyInstr;
  cts_fetch_s fetchReq;
  cts_alert_s alerts;
  int nErrors = 0, checksDone = 0;

  cts_core_shell #(
    .protection_unit_on(1'b1), .protection_match_granule(3), .protection_region_count(16),
    .event_counter_count(10), .reduced_register_base(1'b1), .branch_target_adder_on(1'b1),
    .multiply_variant_select(CTS_MUL_SINGLE), .bitmanip_variant_select(CTS_BIT_FULL),
    .register_store_style(CTS_RF_LATCH), .fetch_cache_on(1'b1), .fetch_cache_correction_on(1'b1)
  ) u_cts_core_shell (
    .clk, .rst_n, .testEnable, .testResetLowIn(1'b1),
    .ramCfgIn, .ramCfgOut, .threadIdentifierIn(hartId), .bootAddrIn(bootAddr), .fetchEnableIn,
    .fetchReq, .instrGnt, .instrRvalid, .instrErr, .branchTaken, .branchTarget,
    .debugEnter(dbg[0]), .debugException(dbg[1]), .triggerHit(1'b0), .wfiExec,
    .dataOutstanding, .irqPending(wk[0]), .debugReq(wk[1]), .minorFault(flt[2]),
    .majorInternalFault(flt[1]), .majorBusFault(flt[0]), .perfEvent, .alerts, .coreSleep,
    .clkGateEnable, .dummyInstr, .regAddr, .regWdata, .regWrite, .regRead, .regRdata
  );
  cts_mem_model u_cts_mem_model (
    .clk, .rst_n, .slow, .fetchReq, .instrGnt, .instrRvalid, .instrErr
  );

  // clock and run limit
  always #20 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    nErrors++;
    finish_test();
  end

  task automatic finish_test();
    $display("errors %0d checks %0d", nErrors, checksDone);
    if (nErrors == 0 && checksDone > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checksDone++;
    if (s !== e) begin
      nErrors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    d = regRdata;
  endtask
  // address of the current (skip=0) or following fetch request
  task automatic nextReq(input bit skip, output logic [31:0] a);
    int n;
    @(negedge clk);
    for (n = 0; skip && n < 60 && fetchReq.req; n++) @(negedge clk);
    for (n = 0; n < 60 && !fetchReq.req; n++) @(negedge clk);
    a = fetchReq.req ? fetchReq.addr : 32'hDEAD_0000;
  endtask

  task automatic t_boot();
    logic [31:0] a;
    nextReq(1'b0, a);
    chk(a, BOOT + CTS_BOOT_OFFSET);
    nextReq(1'b1, a);
    chk(a, BOOT + CTS_BOOT_OFFSET + CTS_FETCH_STEP);
  endtask
  task automatic t_regs();
    logic [31:0] d, e;
    rd(CTS_REG_HART, d);
    chk(d, HART);
    wr(CTS_REG_HART, 32'h0);
    rd(CTS_REG_HART, d);
    chk(d, HART);
    @(posedge clk);
    hartId <= 32'h0000_00A5;
    rd(CTS_REG_HART, d);
    chk(d, 32'h0000_00A5);
    rd(CTS_REG_LFSR, d);
    chk(d, CTS_SEED_DEF);
    chk(dummyInstr, 32'h0);
    rd(8'h40, d);
    chk(d, 32'h0);
    rd(CTS_REG_CONFIG, d);
    chk(d, CFG);
    wr(CTS_REG_CTRL, 32'h1);
    rd(CTS_REG_CTRL, d);
    chk(d, 32'h1);
    wr(CTS_REG_CTRL, 32'h0);
    rd(CTS_REG_CNT0, d);
    @(posedge clk);
    perfEvent <= 10'h001;
    repeat (3) @(posedge clk);
    perfEvent <= 10'h000;
    rd(CTS_REG_CNT0, e);
    chk(e, d + 32'h3);
  endtask
  task automatic t_misc();
    int k, i, n;
    for (k = 0; k < 3; k++) begin
      @(posedge clk);
      flt <= 3'h1 << k;
      fork
        begin
          repeat (3) @(posedge clk);
          flt <= 3'h0;
        end
      join_none
      n = 0;
      for (i = 0; i < 10; i++) begin
        @(negedge clk);
        n += int'(alerts[k]);
      end
      chk(n, k == 2 ? 1 : 3);
    end
    @(posedge clk);
    ramCfgIn <= 10'h2A5;
    testEnable <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(ramCfgOut, 10'h2A5);
    chk(clkGateEnable, 1'b1);
    @(posedge clk);
    testEnable <= 1'b0;
    slow <= 1'b1;
  endtask
  task automatic t_gate();
    logic [31:0] a;
    int i, n;
    @(posedge clk);
    fetchEnableIn <= 4'hA;
    repeat (12) @(posedge clk);
    n = 0;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      n += int'(fetchReq.req);
    end
    chk(n, 0);
    @(posedge clk);
    fetchEnableIn <= CTS_FETCH_ON_CODE;
    branchTaken <= 1'b1;
    branchTarget <= BRANCH;
    @(posedge clk);
    branchTaken <= 1'b0;
    @(negedge clk);
    chk(fetchReq.req, 1'b0);
    @(negedge clk);
    chk(fetchReq.req, 1'b1);
    chk(fetchReq.addr, BRANCH);
    nextReq(1'b0, a);
    chk(fetchReq.req, 1'b1);
  endtask
  task automatic t_sleep(input int k);
    int n;
    @(posedge clk);
    dataOutstanding <= 1'b1;
    wfiExec <= 1'b1;
    @(posedge clk);
    wfiExec <= 1'b0;
    repeat (6) @(negedge clk);
    chk(coreSleep, 1'b0);
    @(posedge clk);
    dataOutstanding <= 1'b0;
    for (n = 0; n < 40 && coreSleep !== 1'b1; n++) @(negedge clk);
    chk(coreSleep, 1'b1);
    chk(clkGateEnable, 1'b0);
    @(posedge clk);
    testEnable <= 1'b1;
    @(negedge clk);
    @(negedge clk);
    chk(clkGateEnable, 1'b1);
    @(posedge clk);
    testEnable <= 1'b0;
    @(posedge clk);
    wk <= 2'h1 << k;
    @(negedge clk);
    @(negedge clk);
    chk(coreSleep, 1'b0);
    @(posedge clk);
    wk <= 2'h0;
  endtask
  task automatic t_dbg();
    logic [31:0] a;
    int k, i;
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      dbg <= 2'h1 << k;
      @(posedge clk);
      dbg <= 2'h0;
      a = 32'h0;
      for (i = 0; i < 6 && a !== (k ? CTS_DBG_FAULT_DEF : CTS_DBG_ENTRY_DEF); i++)
        nextReq(i != 0, a);
      chk(a, k ? CTS_DBG_FAULT_DEF : CTS_DBG_ENTRY_DEF);
    end
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_boot();
    t_regs();
    t_misc();
    t_gate();
    t_sleep(0);
    t_sleep(1);
    t_dbg();
    finish_test();
  end
endmodule // cts_core_shell_tb
`default_nettype wire

/* verification/cts_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cts_mem_model
  import cts_core_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       slow,
  input  wire cts_fetch_s fetchReq,
  output logic            instrGnt,
  output logic            instrRvalid,
  output logic            instrErr
);
  logic       [1:0] waitCnt;
  logic             busy;
  wire  logic [1:0] lat = slow ? 2'h2 : 2'h0;
  // memory never reports bus errors
  assign instrErr = 1'b0;
  // grant after lat cycles, answer lat cycles after the grant
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instrGnt <= 1'b0;
      instrRvalid <= 1'b0;
      busy <= 1'b0;
      waitCnt <= 2'h0;
    end else begin
      instrGnt <= 1'b0;
      instrRvalid <= 1'b0;
      if (busy || (fetchReq.req && !instrGnt)) begin
        waitCnt <= waitCnt + 2'h1;
        if (waitCnt == lat) begin
          waitCnt <= 2'h0;
          instrGnt <= !busy;
          instrRvalid <= busy;
          busy <= !busy;
        end
      end
    end
  end
endmodule // cts_mem_model
`default_nettype wire
